// File: hdl/uhp_params.svh
// Constants shared by both ends of the parallel host port.
// Assumes nothing of its surroundings; included by its bare name.
`ifndef UHP_PARAMS_SVH
`define UHP_PARAMS_SVH

// Device register offsets, reached through the address pointer.
`define UHP_REG_CTRL      8'h05
`define UHP_REG_IRQ_EN    8'h06
`define UHP_REG_IRQ_STAT  8'h0d
`define UHP_REG_CNT_LO    8'h35
`define UHP_REG_CNT_HI    8'h36

// Device field positions and reset values.
`define UHP_CTRL_DMA_EN   1
`define UHP_CTRL_DMA_DIR  2
`define UHP_IRQ_DMA_DONE  4
`define UHP_IRQ_DMA_BUSY  7
`define UHP_CTRL_RESET    8'h00
`define UHP_IRQ_EN_RESET  8'h00
`define UHP_CNT_RESET     8'h00
`define UHP_DMA_BASE      8'h40
`define UHP_BUS_IDLE      8'hff

// Host command port offsets on AHB-Lite.
`define UHP_H_CMD         8'h00
`define UHP_H_STATUS      8'h04
`define UHP_H_IRQ_STAT    8'h08
`define UHP_H_IRQ_MASK    8'h0c
`define UHP_H_CTRL        8'h10
`define UHP_H_DMA_DATA    8'h14

// Host field positions.
`define UHP_CMD_SEL       8
`define UHP_CMD_RD        9
`define UHP_HCTL_RST      0
`define UHP_HCTL_CM       1
`define UHP_HCTL_DMA_EN   2
`define UHP_HCTL_DMA_RD   3
`define UHP_HIRQ_DONE     0
`define UHP_HIRQ_DEV      1
`define UHP_HIRQ_DMA      2

// Strobe timing.
`define UHP_CLK_NS        8
`define UHP_STROBE_NS     32
`define UHP_STROBE_CYCLES ((`UHP_STROBE_NS + `UHP_CLK_NS - 1) / `UHP_CLK_NS)

`endif

// File: hdl/uhp_pkg.sv
// Types shared by both ends of the parallel host port.
// Assumes nothing of its surroundings.
package uhp_pkg;

    typedef logic [7:0] uhp_byte_t;

    typedef enum logic [1:0] {
        UHP_H_IDLE   = 2'b00,
        UHP_H_SETUP  = 2'b01,
        UHP_H_STROBE = 2'b10,
        UHP_H_HOLD   = 2'b11
    } uhp_host_state_t;

    typedef enum logic {
        UHP_DMA_IDLE = 1'b0,
        UHP_DMA_RUN  = 1'b1
    } uhp_dma_state_t;

endpackage

// File: hdl/uhp_if.sv
// Pins between the external processor and the device port.
// Assumes the bus lines idle high when neither end drives them.
`timescale 1ns/1ns
`include "uhp_params.svh"

interface uhp_if;
    uhp_pkg::uhp_byte_t host_bus_out;
    logic               host_bus_oe_n;
    uhp_pkg::uhp_byte_t dev_bus_out;
    logic               dev_bus_oe_n;
    uhp_pkg::uhp_byte_t bus_line;
    logic               pointer_or_data_select;
    logic               chip_select_low;
    logic               read_strobe_low;
    logic               write_strobe_low;
    logic               dma_grant_low_in;
    logic               dma_request_low_out;
    logic               irq_request_out;
    logic               device_reset_low;
    logic               clock_multiplier_select;

    // Host drive wins a clash so that a fault shows as wrong data, not as X.
    assign bus_line = !host_bus_oe_n ? host_bus_out :
                      (!dev_bus_oe_n ? dev_bus_out : `UHP_BUS_IDLE);

    modport dev (
        input  bus_line, pointer_or_data_select, chip_select_low, read_strobe_low,
        input  write_strobe_low, dma_grant_low_in, device_reset_low,
        input  clock_multiplier_select,
        output dev_bus_out, dev_bus_oe_n, dma_request_low_out, irq_request_out
    );

    modport host (
        input  bus_line, dma_request_low_out, irq_request_out,
        output host_bus_out, host_bus_oe_n, pointer_or_data_select, chip_select_low,
        output read_strobe_low, write_strobe_low, dma_grant_low_in, device_reset_low,
        output clock_multiplier_select
    );
endinterface

// File: hdl/uhp_device.sv
// Device end of the parallel host port: pointer, registers, buffer and DMA.
// Assumes all pins are synchronous to clock and the params header is in scope.
//
// What this block does
// R1 - Upper count byte held in count-high register.
// R2 - Count-high write starts DMA only if enabled.
// R3 - Host writes count low first, then high.
// R4 - Select low targets pointer, write only.
// R5 - Select high targets pointed register, read/write.
// R6 - Multiplexed hosts keep select tied high.
// R7 - DMA uses low request out, low grant in.
// R8 - Read needs read strobe and chip select.
// R9 - Write needs write strobe and chip select.
// R10 - Clock mode input enables 4x multiplier.
// R11 - Reset input low resets the device.
// R12 - Interrupt output driven high to request.
// R13 - Eight bus lines carry data and address.
// R14 - DMA count is sixteen bits, two bytes.
// R15 - Control bit 1 is DMA enable.
// R16 - Control bit 2 sets DMA direction.
// R17 - Pointer keeps last written value for accesses.
// R18 - DMA ends after full count, request drops.
//
// Implementation choice: register access over AHB-Lite.
`timescale 1ns/1ns
`include "uhp_params.svh"

module uhp_device (
    // Clock, reset and enable
    input  wire logic clock,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // Pins to the processor and DMA controller
    uhp_if.dev        link,
    // User side
    output logic      pll_x4_enable,
    output logic      dma_busy
);

    ////////////////////////////////////////////////////////////////////////////
    // Strobe qualification and edges.

    logic               wr_q;
    logic               rd_q;
    logic               dwr_q;
    logic               drd_q;
    uhp_pkg::uhp_byte_t pointer;
    uhp_pkg::uhp_byte_t ctrl;
    uhp_pkg::uhp_byte_t irq_en;
    logic [6:0]         irq_stat;
    uhp_pkg::uhp_byte_t cnt_lo;
    uhp_pkg::uhp_byte_t cnt_hi;
    uhp_pkg::uhp_byte_t dma_addr;
    logic [15:0]        dma_left;
    uhp_pkg::uhp_dma_state_t dma_state;
    uhp_pkg::uhp_byte_t mem [0:255];

    wire soft_rst   = !link.device_reset_low; // R11
    wire cs_act     = !link.chip_select_low;
    wire rd_act     = cs_act && !link.read_strobe_low; // R8
    wire wr_act     = cs_act && !link.write_strobe_low; // R9
    wire dma_on     = (dma_state == uhp_pkg::UHP_DMA_RUN);
    wire dma_dir_rd = ctrl[`UHP_CTRL_DMA_DIR]; // R16
    wire grant      = !link.dma_grant_low_in; // R7
    wire dma_wr     = grant && !link.write_strobe_low;
    wire dma_rd     = grant && !link.read_strobe_low;
    wire wr_pulse   = wr_act && !wr_q;
    wire sel_data   = link.pointer_or_data_select;

    // A read with select low aims at the pointer, which cannot be read back.
    wire ptr_wr     = wr_pulse && !sel_data; // R4
    wire data_wr    = wr_pulse && sel_data; // R5
    wire rd_drive   = rd_act && sel_data; // R5

    ////////////////////////////////////////////////////////////////////////////
    // Register decode.

    wire hit_ctrl   = (pointer == `UHP_REG_CTRL);
    wire hit_irq_en = (pointer == `UHP_REG_IRQ_EN);
    wire hit_stat   = (pointer == `UHP_REG_IRQ_STAT);
    wire hit_cnt_lo = (pointer == `UHP_REG_CNT_LO);
    wire hit_cnt_hi = (pointer == `UHP_REG_CNT_HI);

    // The new high byte is taken from the bus so the start sees this write.
    wire [15:0] start_count = {link.bus_line, cnt_lo}; // R14
    wire        hi_write    = data_wr && hit_cnt_hi;
    wire        dma_start   = hi_write && ctrl[`UHP_CTRL_DMA_EN]; // R2 R15

    // Writes are caught at strobe entry, reads counted at strobe exit,
    // so a read byte is only consumed once the DMA controller has latched it.
    wire dwr_pulse  = dma_wr && !dwr_q;
    wire drd_end    = !dma_rd && drd_q;
    wire dma_step   = dma_on && (dma_dir_rd ? drd_end : dwr_pulse);
    wire dma_last   = dma_step && (dma_left == 16'h0001); // R18
    wire zero_start = dma_start && (start_count == 16'h0000);
    wire dma_done   = dma_last || zero_start;
    wire dma_rd_drv = dma_on && dma_dir_rd && dma_rd;

    wire next_dma_on = dma_start ? (start_count != 16'h0000) :
                       (dma_last ? 1'b0 : dma_on); // R18

    // A set in the same cycle as a clear wins.
    wire [6:0] stat_clr = (data_wr && hit_stat) ? link.bus_line[6:0] : 7'h00;
    wire [6:0] stat_set = {2'b00, dma_done, 4'h0};
    wire [6:0] next_irq_stat = (irq_stat & ~stat_clr) | stat_set;

    wire [7:0] status_rd = {dma_on, irq_stat};
    wire [7:0] rd_value  = hit_ctrl   ? ctrl      :
                           hit_irq_en ? irq_en    :
                           hit_stat   ? status_rd :
                           hit_cnt_lo ? cnt_lo    :
                           hit_cnt_hi ? cnt_hi    : mem[pointer]; // R17

    wire [7:0] next_bus_out = dma_rd_drv ? mem[dma_addr] : rd_value;

    ////////////////////////////////////////////////////////////////////////////
    // Edge history.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wr_q  <= 1'b0;
            rd_q  <= 1'b0;
            dwr_q <= 1'b0;
            drd_q <= 1'b0;
        end else if (clk_en) begin
            wr_q  <= wr_act;
            rd_q  <= rd_act;
            dwr_q <= dma_wr;
            drd_q <= dma_rd;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer and control registers.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            pointer <= 8'h00;
            ctrl    <= `UHP_CTRL_RESET;
            irq_en  <= `UHP_IRQ_EN_RESET;
        end else if (clk_en) begin
            if (soft_rst) begin // R11
                pointer <= 8'h00;
                ctrl    <= `UHP_CTRL_RESET;
                irq_en  <= `UHP_IRQ_EN_RESET;
            end else begin
                if (ptr_wr) begin
                    pointer <= link.bus_line; // R13 R17
                end
                if (data_wr && hit_ctrl) begin
                    ctrl <= link.bus_line;
                end
                if (data_wr && hit_irq_en) begin
                    irq_en <= link.bus_line;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Count registers and interrupt status.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            cnt_lo   <= `UHP_CNT_RESET;
            cnt_hi   <= `UHP_CNT_RESET;
            irq_stat <= 7'h00;
        end else if (clk_en) begin
            if (soft_rst) begin
                cnt_lo   <= `UHP_CNT_RESET;
                cnt_hi   <= `UHP_CNT_RESET;
                irq_stat <= 7'h00;
            end else begin
                if (data_wr && hit_cnt_lo) begin
                    cnt_lo <= link.bus_line;
                end
                if (hi_write) begin
                    cnt_hi <= link.bus_line; // R1
                end
                irq_stat <= next_irq_stat;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // DMA engine.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            dma_state <= uhp_pkg::UHP_DMA_IDLE;
            dma_left  <= 16'h0000;
            dma_addr  <= `UHP_DMA_BASE;
        end else if (clk_en) begin
            if (soft_rst) begin
                dma_state <= uhp_pkg::UHP_DMA_IDLE;
                dma_left  <= 16'h0000;
                dma_addr  <= `UHP_DMA_BASE;
            end else if (dma_start) begin
                dma_state <= next_dma_on ? uhp_pkg::UHP_DMA_RUN : uhp_pkg::UHP_DMA_IDLE;
                dma_left  <= start_count; // R14
                dma_addr  <= `UHP_DMA_BASE;
            end else if (dma_step) begin
                dma_state <= next_dma_on ? uhp_pkg::UHP_DMA_RUN : uhp_pkg::UHP_DMA_IDLE;
                dma_left  <= dma_left - 16'h0001;
                dma_addr  <= dma_addr + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Buffer memory. It is not reset; software must write before it reads.

    always_ff @(posedge clock) begin
        if (clk_en && !soft_rst) begin
            if (data_wr) begin
                mem[pointer] <= link.bus_line; // R5
            end else if (dma_step && !dma_dir_rd) begin
                mem[dma_addr] <= link.bus_line; // R16
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registered pins and user outputs.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            link.dev_bus_out        <= `UHP_BUS_IDLE;
            link.dev_bus_oe_n       <= 1'b1;
            link.dma_request_low_out <= 1'b1;
            link.irq_request_out    <= 1'b0;
            pll_x4_enable           <= 1'b0;
            dma_busy                <= 1'b0;
        end else if (clk_en) begin
            link.dev_bus_out        <= next_bus_out;
            link.dev_bus_oe_n       <= soft_rst || !(rd_drive || dma_rd_drv); // R8
            link.dma_request_low_out <= soft_rst || !next_dma_on; // R7 R18
            link.irq_request_out    <= !soft_rst && |(next_irq_stat & irq_en[6:0]); // R12
            pll_x4_enable           <= link.clock_multiplier_select; // R10
            dma_busy                <= !soft_rst && next_dma_on;
        end
    end

endmodule

// File: hdl/uhp_host.sv
// Processor end of the parallel host port, steered over AHB-Lite.
// Assumes one AHB-Lite master, whole-word single transfers, pins synchronous.
`timescale 1ns/1ns
`include "uhp_params.svh"

module uhp_host (
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        arst_n,
    input  wire logic        clk_en,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    output logic             irq,
    // Pins to the device
    uhp_if.host              link
);

    localparam logic [2:0] STROBE_LAST = 3'(`UHP_STROBE_CYCLES - 1);

    uhp_pkg::uhp_host_state_t state;
    logic [2:0]         step;
    logic               a_wr;
    logic [7:0]         a_addr;
    logic               pend;
    logic [9:0]         cmd;
    logic [3:0]         hctl;
    uhp_pkg::uhp_byte_t dma_tx;
    uhp_pkg::uhp_byte_t dma_rx;
    uhp_pkg::uhp_byte_t rd_data;
    logic [2:0]         irq_stat;
    logic [2:0]         irq_mask;
    logic               op_dma;
    logic               op_rd;
    logic               dev_irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode.

    wire a_phase  = hsel && htrans[1] && hready;
    wire w_cmd    = a_wr && (a_addr == `UHP_H_CMD);
    wire w_mask   = a_wr && (a_addr == `UHP_H_IRQ_MASK);
    wire w_ctl    = a_wr && (a_addr == `UHP_H_CTRL);
    wire w_dma    = a_wr && (a_addr == `UHP_H_DMA_DATA);
    wire r_stat   = a_phase && !hwrite && (haddr[7:0] == `UHP_H_IRQ_STAT);
    wire idle     = (state == uhp_pkg::UHP_H_IDLE);
    wire go_cpu   = idle && pend;
    wire go_dma   = idle && !pend && hctl[`UHP_HCTL_DMA_EN] && !link.dma_request_low_out;
    wire last     = (state == uhp_pkg::UHP_H_STROBE) && (step == STROBE_LAST);
    wire done_evt = (state == uhp_pkg::UHP_H_HOLD) && !op_dma;
    wire dma_evt  = (state == uhp_pkg::UHP_H_HOLD) && op_dma;
    wire dev_rise = link.irq_request_out && !dev_irq_q;

    // A set in the same cycle as the clearing read wins.
    wire [2:0] ev  = {dma_evt, dev_rise, done_evt};
    wire [2:0] next_irq_stat = (r_stat ? 3'b000 : irq_stat) | ev;

    wire [31:0] rd_mux =
        (haddr[7:0] == `UHP_H_CMD)      ? {22'h0, cmd} :
        (haddr[7:0] == `UHP_H_STATUS)   ? {6'h0, !link.dma_request_low_out,
                                           link.irq_request_out, dma_rx, rd_data,
                                           7'h0, pend || !idle} :
        (haddr[7:0] == `UHP_H_IRQ_STAT) ? {29'h0, irq_stat} :
        (haddr[7:0] == `UHP_H_IRQ_MASK) ? {29'h0, irq_mask} :
        (haddr[7:0] == `UHP_H_CTRL)     ? {28'h0, hctl} :
        (haddr[7:0] == `UHP_H_DMA_DATA) ? {24'h0, dma_tx} : 32'h0;

    ////////////////////////////////////////////////////////////////////////////
    // Register file.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            a_wr <= 1'b0;
            a_addr <= 8'h00;
            hrdata <= 32'h0;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            cmd <= 10'h000;
            hctl <= 4'h0;
            dma_tx <= 8'h00;
            irq_mask <= 3'b000;
            irq_stat <= 3'b000;
            irq <= 1'b0;
            dev_irq_q <= 1'b0;
            pend <= 1'b0;
        end else if (clk_en) begin
            a_wr <= a_phase && hwrite;
            a_addr <= haddr[7:0];
            hrdata <= (a_phase && !hwrite) ? rd_mux : 32'h0;
            if (w_cmd && !pend && idle) begin
                cmd <= hwdata[9:0];
            end
            if (w_ctl) begin
                hctl <= hwdata[3:0];
            end
            if (w_dma) begin
                dma_tx <= hwdata[7:0];
            end
            if (w_mask) begin
                irq_mask <= hwdata[2:0];
            end
            irq_stat <= next_irq_stat;
            irq <= |(next_irq_stat & irq_mask);
            dev_irq_q <= link.irq_request_out;
            pend <= (w_cmd && !pend && idle) || (pend && !go_cpu);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin sequencer: setup, strobe, hold, idle.

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state <= uhp_pkg::UHP_H_IDLE;
            step <= 3'd0;
            op_dma <= 1'b0;
            op_rd <= 1'b0;
            rd_data <= 8'h00;
            dma_rx <= 8'h00;
            link.host_bus_out <= `UHP_BUS_IDLE;
            link.host_bus_oe_n <= 1'b1;
            link.pointer_or_data_select <= 1'b1; // R6
            link.chip_select_low <= 1'b1;
            link.read_strobe_low <= 1'b1;
            link.write_strobe_low <= 1'b1;
            link.dma_grant_low_in <= 1'b1;
            link.device_reset_low <= 1'b1;
            link.clock_multiplier_select <= 1'b0;
        end else if (clk_en) begin
            link.device_reset_low <= !hctl[`UHP_HCTL_RST];
            link.clock_multiplier_select <= hctl[`UHP_HCTL_CM];
            unique case (state)
                uhp_pkg::UHP_H_IDLE: begin
                    if (go_cpu || go_dma) begin
                        op_dma <= go_dma;
                        op_rd <= go_dma ? hctl[`UHP_HCTL_DMA_RD] : cmd[`UHP_CMD_RD];
                        link.host_bus_out <= go_dma ? dma_tx : cmd[7:0];
                        link.host_bus_oe_n <= go_dma ? hctl[`UHP_HCTL_DMA_RD] : cmd[`UHP_CMD_RD];
                        link.pointer_or_data_select <= go_dma || cmd[`UHP_CMD_SEL];
                        link.chip_select_low <= go_dma;
                        link.dma_grant_low_in <= !go_dma;
                        state <= uhp_pkg::UHP_H_SETUP;
                    end
                end
                uhp_pkg::UHP_H_SETUP: begin
                    link.read_strobe_low <= !op_rd;
                    link.write_strobe_low <= op_rd;
                    step <= 3'd0;
                    state <= uhp_pkg::UHP_H_STROBE;
                end
                uhp_pkg::UHP_H_STROBE: begin
                    step <= step + 3'd1;
                    if (last) begin
                        if (op_rd && op_dma) begin
                            dma_rx <= link.bus_line;
                        end else if (op_rd) begin
                            rd_data <= link.bus_line;
                        end
                        link.read_strobe_low <= 1'b1;
                        link.write_strobe_low <= 1'b1;
                        state <= uhp_pkg::UHP_H_HOLD;
                    end
                end
                uhp_pkg::UHP_H_HOLD: begin
                    link.host_bus_oe_n <= 1'b1;
                    link.chip_select_low <= 1'b1;
                    link.dma_grant_low_in <= 1'b1;
                    state <= uhp_pkg::UHP_H_IDLE;
                end
            endcase
        end
    end

endmodule

// File: dv/uhp_checker.sv
// Concurrent checks on the pins between the processor end and the device end.
// Assumes both ends run on one clock; instantiated beside the interface.
`timescale 1ns/1ns

module uhp_checker (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pins
    input wire logic chip_select_low,
    input wire logic read_strobe_low,
    input wire logic write_strobe_low,
    input wire logic pointer_or_data_select,
    input wire logic dma_grant_low_in,
    input wire logic dma_request_low_out,
    input wire logic irq_request_out,
    input wire logic device_reset_low,
    input wire logic host_bus_oe_n,
    input wire logic dev_bus_oe_n
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_rd_pulse;
        !read_strobe_low [*4] ##1 read_strobe_low;
    endsequence
    sequence s_wr_pulse;
        !write_strobe_low [*4] ##1 write_strobe_low;
    endsequence
    sequence s_dev_idle;
        dev_bus_oe_n && dma_request_low_out && !irq_request_out;
    endsequence

    AST_RD_NEEDS_STROBE: assert property (!dev_bus_oe_n |->
        !$past(read_strobe_low) || !$past(read_strobe_low, 2))
        else $error("device drives bus without a read strobe");
    AST_RD_QUALIFIED: assert property (!read_strobe_low |->
        !chip_select_low || !dma_grant_low_in) else $error("read strobe without select");
    AST_WR_QUALIFIED: assert property (!write_strobe_low |->
        !chip_select_low || !dma_grant_low_in) else $error("write strobe without select");
    AST_RD_LENGTH: assert property ($fell(read_strobe_low) |-> s_rd_pulse)
        else $error("read strobe length wrong");
    AST_WR_LENGTH: assert property ($fell(write_strobe_low) |-> s_wr_pulse)
        else $error("write strobe length wrong");
    AST_PTR_NOT_READ: assert property ((!chip_select_low && !read_strobe_low
        && !pointer_or_data_select) |=> dev_bus_oe_n) else $error("pointer read answered");
    AST_NO_CLASH: assert property (!(!host_bus_oe_n && !dev_bus_oe_n))
        else $error("both ends drive the bus");
    AST_GRANT_AFTER_REQ: assert property ($fell(dma_grant_low_in) |->
        !$past(dma_request_low_out)) else $error("grant without request");
    AST_IRQ_AFTER_DMA: assert property ($rose(irq_request_out) |-> dma_request_low_out)
        else $error("interrupt while request pending");
    AST_DEV_RESET: assert property (!device_reset_low |=> ##1 s_dev_idle)
        else $error("device not idle in reset");
endmodule

// File: dv/tb.sv
// Self-checking bench: AHB-Lite master driving the processor end into the device.
// Assumes the params header is on the include path.
`timescale 1ns/1ns
`include "uhp_params.svh"

module tb;
    logic        clock;
    logic        arst_n;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        irq;
    logic        pll_x4_enable;
    logic        dma_busy;
    logic [31:0] q;
    logic [31:0] seed;
    logic [7:0]  a;
    logic [7:0]  b;
    int          fail_count;
    int          num_checks;
    int          cyc = 0;

    uhp_if uhp_if_i ();
    uhp_host uhp_host_i (.clock(clock), .arst_n(arst_n), .clk_en(1'b1), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .irq(irq), .link(uhp_if_i.host));
    uhp_device uhp_device_i (.clock(clock), .arst_n(arst_n), .clk_en(1'b1),
        .link(uhp_if_i.dev), .pll_x4_enable(pll_x4_enable), .dma_busy(dma_busy));
    uhp_checker uhp_checker_i (.clock(clock), .arst_n(arst_n),
        .chip_select_low(uhp_if_i.chip_select_low), .read_strobe_low(uhp_if_i.read_strobe_low),
        .write_strobe_low(uhp_if_i.write_strobe_low),
        .pointer_or_data_select(uhp_if_i.pointer_or_data_select),
        .dma_grant_low_in(uhp_if_i.dma_grant_low_in),
        .dma_request_low_out(uhp_if_i.dma_request_low_out),
        .irq_request_out(uhp_if_i.irq_request_out),
        .device_reset_low(uhp_if_i.device_reset_low),
        .host_bus_oe_n(uhp_if_i.host_bus_oe_n), .dev_bus_oe_n(uhp_if_i.dev_bus_oe_n));

    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction
    function automatic logic [31:0] cmdw(input logic rd, input logic sel, input logic [7:0] v);
        return {22'h000000, rd, sel, v};
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Read data lands in q; the address phase is held until hready is seen high.
    task ahb(input logic w, input logic [7:0] ad, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h000000, ad};
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        q = hrdata;
        chk(hresp, 32'h0);
    endtask
    // The extra cycles let busy rise before the first status poll.
    task dev(input logic [31:0] c);
        ahb(1'b1, `UHP_H_CMD, c);
        repeat (2) @(posedge clock);
        do ahb(1'b0, `UHP_H_STATUS, 32'h0); while (q[0] !== 1'b0);
    endtask
    task dwr(input logic [7:0] p, input logic [7:0] v);
        dev(cmdw(1'b0, 1'b0, p));
        dev(cmdw(1'b0, 1'b1, v));
    endtask
    task drd(input logic [7:0] p);
        dev(cmdw(1'b0, 1'b0, p));
        dev(cmdw(1'b1, 1'b1, 8'h00));
    endtask
    task dma_wait;
        do @(posedge clock); while (dma_busy !== 1'b0);
        repeat (4) @(posedge clock);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 8000) begin
            fail_count++;
            wrap_up;
        end
    end
    initial begin
        arst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hwdata = 32'h0;
        fail_count = 0;
        num_checks = 0;
        seed = 32'hb596;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        ahb(1'b1, `UHP_H_IRQ_MASK, 32'h4);
        for (int i = 0; i < 4; i++) begin
            seed = xs(seed);
            a = 8'h10 + {4'h0, seed[3:0]};
            b = seed[15:8];
            dwr(a, b);
            drd(a);
            chk(q[15:8], b);
        end
        dev(cmdw(1'b1, 1'b0, 8'h05));
        chk(q[15:8], `UHP_BUS_IDLE);
        seed = xs(seed);
        dwr(`UHP_REG_CNT_LO, 8'h03);
        dwr(`UHP_REG_CNT_HI, seed[7:0]);
        chk(dma_busy, 32'h0);
        drd(`UHP_REG_CNT_HI);
        chk(q[15:8], seed[7:0]);
        drd(`UHP_REG_CNT_LO);
        chk(q[15:8], 32'h3);
        chk(irq, 32'h0);
        b = seed[23:16];
        ahb(1'b1, `UHP_H_DMA_DATA, {24'h000000, b});
        ahb(1'b1, `UHP_H_CTRL, 32'h4);
        dwr(`UHP_REG_IRQ_EN, 8'h10);
        dwr(`UHP_REG_CTRL, 8'h02);
        dwr(`UHP_REG_CNT_HI, 8'h00);
        dma_wait;
        chk(irq, 32'h1);
        ahb(1'b0, `UHP_H_IRQ_STAT, 32'h0);
        chk(q[2:0], 32'h7);
        repeat (2) @(posedge clock);
        chk(irq, 32'h0);
        drd(`UHP_REG_IRQ_STAT);
        chk(q[15:8], 32'h10);
        drd(`UHP_DMA_BASE);
        chk(q[15:8], b);
        drd(`UHP_DMA_BASE + 8'h02);
        chk(q[15:8], b);
        ahb(1'b1, `UHP_H_CTRL, 32'hc);
        dwr(`UHP_REG_CTRL, 8'h06);
        dwr(`UHP_REG_CNT_LO, 8'h01);
        dwr(`UHP_REG_CNT_HI, 8'h00);
        dma_wait;
        ahb(1'b0, `UHP_H_STATUS, 32'h0);
        chk(q[23:16], b);
        ahb(1'b1, `UHP_H_CTRL, 32'h3);
        repeat (4) @(posedge clock);
        chk(pll_x4_enable, 32'h1);
        ahb(1'b1, `UHP_H_CTRL, 32'h0);
        drd(`UHP_REG_CTRL);
        chk(q[15:8], `UHP_CTRL_RESET);
        ahb(1'b0, 8'h20, 32'h0);
        chk(q, 32'h0);
        wrap_up;
    end
endmodule
